/* code_to_binary.sv */
`default_nettype none
module code_to_binary (
  input wire logic [13:0] code_in,
  input wire logic twos_complement_format,
  output logic [13:0] code_out
);
  always_comb begin
    code_out = code_in ^ (twos_complement_format ? fmt_pkg::CODE_MSB_MASK : 14'h0000);
  end
endmodule
`default_nettype wire

/* dac_code_format_offset_ctrl.sv */
// Behaviour
// - strap low: channel and offset words are straight binary
// - strap high: channel and offset words are twos complement
// - binary 0000h lowest, 2000h midscale, 3fffh top minus one step
// - twos complement 2000h lowest, 0000h midscale, 1fffh top minus one
// - gain calibration words are always straight binary
// - zero calibration words are always twos complement
// - read-back returns the word as written
// - two independent 14-bit offset codes, groups a and b
// - larger offset code moves group outputs more negative
// - after reset offset codes take the format and range default
// - gain change reloads offset codes with new gain default
// - gain six default offset code 2666h straight binary
// - gain four default offset code 10923 decimal
// - single supply keeps offset dac off, amplifier high impedance
// - gain calibration resets to 8192, zero calibration to zero
// - one gain bit selects amplifier gain of six or four
`default_nettype none
module dac_code_format_offset_ctrl #(
  parameter int CODE_W = fmt_pkg::CODE_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic format_select_strap,
  input wire logic single_supply,
  input wire logic gain_sel_six,
  input wire logic chan_wr,
  input wire logic [13:0] chan_wdata,
  input wire logic ofs_wr,
  input wire logic ofs_grp,
  input wire logic [13:0] ofs_wdata,
  input wire logic gain_cal_wr,
  input wire logic [13:0] gain_cal_wdata,
  input wire logic zero_cal_wr,
  input wire logic [13:0] zero_cal_wdata,
  output logic [13:0] chan_code_bin,
  output logic [13:0] ofs_code_a_bin,
  output logic [13:0] ofs_code_b_bin,
  output logic ofs_enable,
  output logic amp_drive_en,
  output logic amp_gain_six,
  output logic [13:0] ofs_rd_a,
  output logic [13:0] ofs_rd_b,
  output logic [13:0] gain_cal_rd,
  output logic [13:0] zero_cal_rd,
  output logic [13:0] gain_cal_bin,
  output logic [13:0] zero_cal_bin
);
  if (CODE_W != 14 || fmt_pkg::GRP_N != 2) begin : g_param_check
    $error("code width must be 14 and group count must be 2");
  end

  logic strap_s1_reg, strap_s2_reg, supply_s1_reg, supply_s2_reg;
  logic strap_s1_next, strap_s2_next, supply_s1_next, supply_s2_next;
  logic [13:0] ofs_reg [fmt_pkg::GRP_N];
  logic [13:0] ofs_next [fmt_pkg::GRP_N];
  logic [13:0] chan_reg, chan_next, gcal_reg, gcal_next, zcal_reg, zcal_next;
  logic gain_reg, gain_next, init_done;
  logic [1:0] init_cnt_reg, init_cnt_next;
  logic [13:0] chan_conv, def_code;
  logic [13:0] ofs_conv [fmt_pkg::GRP_N];
  logic [13:0] chan_code_bin_next, ofs_code_a_bin_next, ofs_code_b_bin_next;
  logic ofs_enable_next, amp_drive_en_next, amp_gain_six_next;
  logic [13:0] ofs_rd_a_next, ofs_rd_b_next, gain_cal_rd_next, zero_cal_rd_next;
  logic [13:0] gain_cal_bin_next, zero_cal_bin_next;

  // defaults keep reloading until the strap synchroniser has settled
  assign init_done = (init_cnt_reg == fmt_pkg::INIT_LOADS);

  // offset default in written format: binary default, msb flipped for twos complement
  // the new gain selects the default, so a change reloads the right code
  always_comb begin
    def_code = gain_next ? fmt_pkg::OFFSET_DEF_G6 : fmt_pkg::OFFSET_DEF_G4;
    if (strap_s2_reg) def_code = def_code ^ fmt_pkg::CODE_MSB_MASK;
  end

  always_comb begin
    strap_s1_next = format_select_strap;
    strap_s2_next = strap_s1_reg;
    supply_s1_next = single_supply;
    supply_s2_next = supply_s1_reg;
    gain_next = gain_sel_six;
    init_cnt_next = init_cnt_reg;
    if (!init_done) init_cnt_next = init_cnt_reg + 2'h1;
    chan_next = chan_wr ? chan_wdata : chan_reg;
    gcal_next = gain_cal_wr ? gain_cal_wdata : gcal_reg;
    zcal_next = zero_cal_wr ? zero_cal_wdata : zcal_reg;
    for (int g = 0; g < fmt_pkg::GRP_N; g++) begin
      ofs_next[g] = ofs_reg[g];
      if (!init_done || gain_next != gain_reg) begin
        ofs_next[g] = def_code;
      end else if (ofs_wr && ofs_grp == g[0]) begin
        ofs_next[g] = ofs_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      supply_s1_reg <= 1'b0;
      supply_s2_reg <= 1'b0;
      gain_reg <= 1'b1;
      init_cnt_reg <= 2'h0;
      chan_reg <= 14'h0000;
      gcal_reg <= fmt_pkg::GAIN_CAL_RESET;
      zcal_reg <= fmt_pkg::ZERO_CAL_RESET;
      for (int g = 0; g < fmt_pkg::GRP_N; g++) ofs_reg[g] <= fmt_pkg::OFFSET_DEF_G6;
    end else if (clk_en) begin
      strap_s1_reg <= strap_s1_next;
      strap_s2_reg <= strap_s2_next;
      supply_s1_reg <= supply_s1_next;
      supply_s2_reg <= supply_s2_next;
      gain_reg <= gain_next;
      init_cnt_reg <= init_cnt_next;
      chan_reg <= chan_next;
      gcal_reg <= gcal_next;
      zcal_reg <= zcal_next;
      for (int g = 0; g < fmt_pkg::GRP_N; g++) ofs_reg[g] <= ofs_next[g];
    end
  end

  code_to_binary u_chan (
    .code_in(chan_reg),
    .twos_complement_format(strap_s2_reg),
    .code_out(chan_conv)
  );
  for (genvar gi = 0; gi < fmt_pkg::GRP_N; gi++) begin : g_ofs_conv
    code_to_binary u_ofs (
      .code_in(ofs_reg[gi]),
      .twos_complement_format(strap_s2_reg),
      .code_out(ofs_conv[gi])
    );
  end

  // output next values; every output leaves through a flip-flop
  always_comb begin
    chan_code_bin_next = chan_conv;
    // the analog path subtracts this code, so larger is more negative
    ofs_code_a_bin_next = supply_s2_reg ? fmt_pkg::OFFSET_OFF_CODE : ofs_conv[0];
    ofs_code_b_bin_next = supply_s2_reg ? fmt_pkg::OFFSET_OFF_CODE : ofs_conv[1];
    ofs_enable_next = !supply_s2_reg;
    amp_drive_en_next = !supply_s2_reg;
    amp_gain_six_next = gain_reg;
    ofs_rd_a_next = ofs_reg[0];
    ofs_rd_b_next = ofs_reg[1];
    gain_cal_rd_next = gcal_reg;
    zero_cal_rd_next = zcal_reg;
    gain_cal_bin_next = gcal_reg;
    zero_cal_bin_next = zcal_reg ^ fmt_pkg::CODE_MSB_MASK;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_code_bin <= 14'h0000;
      ofs_code_a_bin <= fmt_pkg::OFFSET_OFF_CODE;
      ofs_code_b_bin <= fmt_pkg::OFFSET_OFF_CODE;
      ofs_enable <= 1'b0;
      amp_drive_en <= 1'b0;
      amp_gain_six <= 1'b1;
      ofs_rd_a <= 14'h0000;
      ofs_rd_b <= 14'h0000;
      gain_cal_rd <= fmt_pkg::GAIN_CAL_RESET;
      zero_cal_rd <= fmt_pkg::ZERO_CAL_RESET;
      gain_cal_bin <= fmt_pkg::GAIN_CAL_RESET;
      zero_cal_bin <= fmt_pkg::ZERO_CAL_RESET ^ fmt_pkg::CODE_MSB_MASK;
    end else if (clk_en) begin
      chan_code_bin <= chan_code_bin_next;
      ofs_code_a_bin <= ofs_code_a_bin_next;
      ofs_code_b_bin <= ofs_code_b_bin_next;
      ofs_enable <= ofs_enable_next;
      amp_drive_en <= amp_drive_en_next;
      amp_gain_six <= amp_gain_six_next;
      ofs_rd_a <= ofs_rd_a_next;
      ofs_rd_b <= ofs_rd_b_next;
      gain_cal_rd <= gain_cal_rd_next;
      zero_cal_rd <= zero_cal_rd_next;
      gain_cal_bin <= gain_cal_bin_next;
      zero_cal_bin <= zero_cal_bin_next;
    end
  end

  // write, or an enabled cycle for the gain bit, then one more enabled cycle to reach the outputs
  sequence s_gcal_write;
    clk_en && gain_cal_wr ##1 clk_en;
  endsequence
  sequence s_zcal_write;
    clk_en && zero_cal_wr ##1 clk_en && !zero_cal_wr;
  endsequence
  sequence s_two_enabled;
    clk_en ##1 clk_en;
  endsequence

  a_single_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && supply_s2_reg |=> !ofs_enable && !amp_drive_en && ofs_code_a_bin == 14'h0000)
    else $error("offset dac not off in single supply");
  a_dual_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !supply_s2_reg |=> ofs_enable && amp_drive_en)
    else $error("offset dac not on in dual supply");
  a_gain_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && init_done && gain_next != gain_reg
      |=> ofs_reg[0] == ofs_reg[1]
      && ofs_reg[0] == ((gain_reg ? 14'h2666 : 14'h2aab)
      ^ ($past(strap_s2_reg) ? 14'h2000 : 14'h0000)))
    else $error("offset code not reloaded on gain change");
  a_init_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && init_cnt_reg == fmt_pkg::INIT_LOADS - 2'h1
      |=> ofs_reg[0] == ofs_reg[1]
      && ofs_reg[0] == ((gain_reg ? 14'h2666 : 14'h2aab)
      ^ ($past(strap_s2_reg) ? 14'h2000 : 14'h0000)))
    else $error("offset code not at default after reset");
  a_chan_conv: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> chan_code_bin == (($past(chan_reg)) ^ ($past(strap_s2_reg) ? 14'h2000 : 14'h0000)))
    else $error("channel conversion wrong");
  a_rd_same: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_gcal_write |=> gain_cal_rd == $past(gain_cal_wdata, 2))
    else $error("gain cal read-back differs");
  a_zero_fmt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_zcal_write |=> zero_cal_bin == ($past(zero_cal_wdata, 2) ^ 14'h2000))
    else $error("zero cal not twos complement");
  a_def_g6: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gain_next && !strap_s2_reg |-> def_code == 14'h2666)
    else $error("gain six default wrong");
  a_def_g4: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gain_next && !strap_s2_reg |-> def_code == 14'h2aab)
    else $error("gain four default wrong");
  a_def_tc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gain_next && strap_s2_reg |-> def_code == 14'h0666)
    else $error("twos complement default wrong");
  a_gain_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_two_enabled |=> amp_gain_six == $past(gain_sel_six, 2))
    else $error("amplifier gain does not follow gain bit");
  a_ofs_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && init_done && ofs_wr && !ofs_grp && gain_next == gain_reg
      |=> ofs_reg[0] == $past(ofs_wdata))
    else $error("offset a write lost");
endmodule
`default_nettype wire

/* dac_code_format_offset_ctrl_tb.sv */
`default_nettype none
module dac_code_format_offset_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, format_select_strap = 1'b0;
  logic single_supply = 1'b0, gain_sel_six = 1'b1, chan_wr, ofs_wr, ofs_grp;
  logic gain_cal_wr, zero_cal_wr, ofs_enable, amp_drive_en, amp_gain_six;
  logic [13:0] chan_wdata, ofs_wdata, gain_cal_wdata, zero_cal_wdata, chan_code_bin;
  logic [13:0] ofs_code_a_bin, ofs_code_b_bin, ofs_rd_a, ofs_rd_b;
  logic [13:0] gain_cal_rd, zero_cal_rd, gain_cal_bin, zero_cal_bin;
  int n_fail = 0;
  int check_count = 0;
  logic [13:0] cin [5] = '{14'h0000, 14'h3fff, 14'h2000, 14'h1fff, 14'h0000};
  logic [13:0] cexp [5] = '{14'h0000, 14'h3fff, 14'h0000, 14'h3fff, 14'h2000};
  dac_code_format_offset_ctrl u_dut (.*);
  host_model u_host (.*);
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [13:0] s, input logic [13:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic close_out();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk(ofs_code_a_bin, 14'h2666);
    chk(ofs_rd_b, 14'h2666);
    chk(gain_cal_rd, 14'h2000);
    chk(zero_cal_rd, 14'h0000);
    chk({13'h0, ofs_enable}, 14'h0001);
    chk({13'h0, amp_gain_six}, 14'h0001);
  endtask
  task automatic t_gain();
    gain_sel_six = 1'b0;
    wait_c(3);
    chk(ofs_rd_a, 14'h2aab);
    chk({13'h0, amp_gain_six}, 14'h0000);
    gain_sel_six = 1'b1;
    wait_c(3);
    chk(ofs_rd_b, 14'h2666);
  endtask
  task automatic t_chan();
    for (int i = 0; i < 5; i++) begin
      if (i == 2) begin
        format_select_strap = 1'b1;
        wait_c(4);
      end
      u_host.wr(2'h0, cin[i], 1'b0);
      chk(chan_code_bin, cexp[i]);
    end
  endtask
  task automatic t_ofs_cal();
    u_host.wr(2'h1, 14'h1234, 1'b0);
    u_host.wr(2'h1, 14'h0abc, 1'b1);
    u_host.wr(2'h2, 14'h1fff, 1'b0);
    u_host.wr(2'h3, 14'h3fff, 1'b0);
    chk(ofs_rd_a, 14'h1234);
    chk(ofs_code_a_bin, 14'h3234);
    chk(ofs_code_b_bin, 14'h2abc);
    chk(gain_cal_bin, 14'h1fff);
    chk(gain_cal_rd, 14'h1fff);
    chk(zero_cal_bin, 14'h1fff);
    chk(zero_cal_rd, 14'h3fff);
  endtask
  task automatic t_reset_tc();
    rst_n = 1'b0;
    gain_sel_six = 1'b0;
    wait_c(2);
    chk(gain_cal_rd, 14'h2000);
    chk(zero_cal_rd, 14'h0000);
    rst_n = 1'b1;
    wait_c(5);
    chk(ofs_rd_a, 14'h0aab);
    chk(ofs_code_b_bin, 14'h2aab);
    chk(chan_code_bin, 14'h2000);
  endtask
  task automatic t_single();
    single_supply = 1'b1;
    wait_c(4);
    chk({13'h0, ofs_enable}, 14'h0000);
    chk({13'h0, amp_drive_en}, 14'h0000);
    chk(ofs_code_a_bin, 14'h0000);
    clk_en = 1'b0;
    single_supply = 1'b0;
    wait_c(4);
    chk({13'h0, ofs_enable}, 14'h0000);
    clk_en = 1'b1;
    wait_c(4);
    chk({13'h0, amp_drive_en}, 14'h0001);
    chk(ofs_code_a_bin, 14'h2aab);
  endtask
  initial begin
    wait_c(5);
    rst_n = 1'b1;
    wait_c(4);
    t_reset();
    t_gain();
    t_chan();
    t_ofs_cal();
    t_reset_tc();
    t_single();
    close_out();
  end
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire

/* fmt_pkg.sv */
`default_nettype none
package fmt_pkg;
  localparam int CODE_W = 14;
  localparam logic [13:0] CODE_MSB_MASK = 14'h2000;
  localparam logic [13:0] GAIN_CAL_RESET = 14'h2000;
  localparam logic [13:0] ZERO_CAL_RESET = 14'h0000;
  localparam logic [13:0] OFFSET_DEF_G6 = 14'h2666;
  localparam logic [13:0] OFFSET_DEF_G4 = 14'h2aab;
  localparam logic [13:0] OFFSET_OFF_CODE = 14'h0000;
  localparam int GRP_N = 2;
  localparam int SYNC_STAGES = 2;
  // default reloads after reset: the strap synchroniser plus the load itself
  localparam logic [1:0] INIT_LOADS = 2'(SYNC_STAGES + 1);
endpackage
`default_nettype wire

/* host_model.sv */
`default_nettype none
module host_model (
  input wire logic clk_sys,
  output logic chan_wr,
  output logic [13:0] chan_wdata,
  output logic ofs_wr,
  output logic ofs_grp,
  output logic [13:0] ofs_wdata,
  output logic gain_cal_wr,
  output logic [13:0] gain_cal_wdata,
  output logic zero_cal_wr,
  output logic [13:0] zero_cal_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] dat;
  assign chan_wdata = dat;
  assign ofs_wdata = dat;
  assign gain_cal_wdata = dat;
  assign zero_cal_wdata = dat;
  initial begin
    {chan_wr, ofs_wr, gain_cal_wr, zero_cal_wr} = 4'h0;
    ofs_grp = 1'b0;
    dat = 14'h0000;
  end
  // kind 0 channel, 1 offset, 2 gain cal, 3 zero cal; one-cycle strobe
  task automatic wr(input logic [1:0] k, input logic [13:0] d, input logic g);
    {chan_wr, ofs_wr, gain_cal_wr, zero_cal_wr} = 4'h8 >> k;
    dat = d;
    ofs_grp = g;
    @(posedge clk_sys);
    #1;
    {chan_wr, ofs_wr, gain_cal_wr, zero_cal_wr} = 4'h0;
    // released data shows the inverse so stale values never pass
    dat = ~d;
    @(posedge clk_sys);
    #1;
  endtask
endmodule
`default_nettype wire
